// ### logic/link_ctrl_pkg.sv
// package: register map, field layout, timing constants and types of the link control block
//
// Functional notes
// RULE_01: run equalizer adaptation during lock, then re-trigger it about once per second.
// RULE_02: spread clocking accepts 10-40 kHz modulation and 0 to 0.125 percent deviation.
// RULE_03: without spread clocking, receive logic tolerates half a percent frequency deviation.
// RULE_04: line monitor reports open, short to battery, short to ground, line-to-line.
// RULE_05: line monitor resets disabled, is configured by registers, status is readable.
// RULE_06: a fault drives the low-active error output only when not masked.
// RULE_07: line-to-line short in twisted-pair mode reported from monitors zero and one only.
// RULE_08: lock asserts only while the local receive path is locked.
// RULE_09: video and control channels become usable as soon as lock asserts.
// RULE_10: lock is reached automatically after power-up without host transactions.
// RULE_11: lock shows on an open-drain indicator and in a status register bit.
// RULE_12: lock runs from the reference clock alone; pixel clock never gates it.
// RULE_13: lock sequence starts on power-down pin release or link-reset bit clear.
// RULE_14: host holds both ends in power-down or link-reset with overlapping intervals.
// RULE_15: host releases the two ends within 90 ms of each other.
// RULE_16: lock time runs from the later release until lock asserts.
// RULE_17: host waits 100 ms after lock loss before issuing its own reset.
// RULE_18: a single serial link only; no dual-link or splitter configuration.
// RULE_19: forward rate fixed at 3, 6 or 12 Gbps; reverse fixed at 187.5 Mbps.
// RULE_20: in 12 Gbps mode forward error correction is forced active; here forced only by rate code 2, not when code 3 keeps 12 Gbps.
// RULE_21: on receive lock loss, drop lock indication and retry acquisition automatically.
package link_ctrl_pkg;

  // register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] STATUS_OFS    = 8'h04;
  localparam logic [7:0] SPREAD_OFS    = 8'h08;
  localparam logic [7:0] MON_CFG_OFS   = 8'h0C;
  localparam logic [7:0] MON_STAT_OFS  = 8'h10;
  localparam logic [7:0] LOCK_TIME_OFS = 8'h14;

  // control register fields
  localparam int CTRL_LINK_RESET_BIT = 0;
  localparam int CTRL_FEC_BIT        = 1;
  localparam int CTRL_RATE_LSB       = 2;    // two bits
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // spread clocking fields: enable bit 0, deviation [11:4] in 0.001 %, freq [23:16] kHz
  localparam int SPREAD_EN_BIT   = 0;
  localparam int SPREAD_DEV_LSB  = 4;
  localparam int SPREAD_FREQ_LSB = 16;
  localparam logic [31:0] SPREAD_RESET = 32'h000A_0000;
  localparam logic [7:0] SPREAD_FREQ_MIN = 8'h0A;  // 10 kHz
  localparam logic [7:0] SPREAD_FREQ_MAX = 8'h28;  // 40 kHz
  localparam logic [7:0] SPREAD_DEV_MAX  = 8'h7D;  // 0.125 %
  localparam logic [7:0] RX_TOL_NO_SPREAD = 8'h05; // 0.5 % in tenths of a percent

  // monitor configuration: enable [0], twisted pair [1], fault mask [7:4]
  localparam int MON_EN_BIT    = 0;
  localparam int MON_STP_BIT   = 1;
  localparam int MON_MASK_LSB  = 4;
  localparam logic [31:0] MON_CFG_RESET = 32'h0000_0000;

  // status fields
  localparam int STAT_LOCK_BIT   = 0;
  localparam int STAT_STATE_LSB  = 1;  // two bits
  localparam int STAT_FEC_BIT    = 3;
  localparam int STAT_RX_OK_BIT  = 4;
  localparam int STAT_AEQ_CNT_LSB = 8; // eight bits

  // rate codes
  localparam logic [1:0] RATE_3G  = 2'h0;
  localparam logic [1:0] RATE_6G  = 2'h1;
  localparam logic [1:0] RATE_12G = 2'h2;

  // timing
  localparam longint CLK_HZ       = 10_000_000;
  localparam longint AEQ_PERIOD_MS = 1000;
  localparam longint AEQ_PERIOD_CYC = CLK_HZ * AEQ_PERIOD_MS / 1000;

  // fault classes, one bit each
  typedef struct packed {
    logic line_short;
    logic short_gnd;
    logic short_bat;
    logic open;
  } fault_t;

  typedef enum logic [1:0] {
    ST_DOWN    = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_LOCKED  = 2'b10
  } link_state_t;

  // per-monitor raw condition from the analog comparators
  typedef struct packed {
    logic high;   // line pulled to battery
    logic low;    // line pulled to ground
    logic open;   // no pulldown seen
  } mon_raw_t;

endpackage

// ### logic/link_lock_and_line_fault_ctrl.sv
// link lock sequencer, equalizer scheduler, spread clocking settings and line-fault reporter
//
// Chosen here: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
module link_lock_and_line_fault_ctrl
  import link_ctrl_pkg::*;
#(
  parameter int     MON_N        = 4,
  parameter longint AEQ_CYCLES   = AEQ_PERIOD_CYC,
  parameter int     AEQ_CNT_W    = 24
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // pins and link-side signals
  input  wire logic              power_down_n_pin,
  input  wire logic              rx_path_locked,
  input  wire mon_raw_t [MON_N-1:0] line_monitor_inputs,
  input  wire logic              aeq_done,
  output logic                   aeq_start,
  output logic                   lock_od_oe,
  output logic                   lock_out,
  output logic                   error_out_n,
  output logic                   channels_enable,
  output logic [1:0]             fwd_rate,
  output logic                   fec_enable,
  output logic                   spread_clocking,
  output logic [7:0]             spread_freq_khz,
  output logic [7:0]             spread_dev,
  output logic [7:0]             rx_tolerance
);

  // synchronisers for pin inputs: three stages, change when 2 and 3 agree
  logic [2:0] pd_sync;
  logic [2:0] rx_sync;
  logic       pd_n;
  logic       rx_ok;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_sync <= 3'h0;
      rx_sync <= 3'h0;
    end else begin
      pd_sync <= {pd_sync[1:0], power_down_n_pin};
      rx_sync <= {rx_sync[1:0], rx_path_locked};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pd_n  <= 1'b0;
      rx_ok <= 1'b0;
    end else begin
      if (pd_sync[1] == pd_sync[2]) pd_n <= pd_sync[2];
      if (rx_sync[1] == rx_sync[2]) rx_ok <= rx_sync[2];
    end
  end

  // monitor inputs: per-monitor three-stage filter
  mon_raw_t [MON_N-1:0] mon_s1;
  mon_raw_t [MON_N-1:0] mon_s2;
  mon_raw_t [MON_N-1:0] mon_s3;
  mon_raw_t [MON_N-1:0] mon_q;
  genvar g;
  generate
    for (g = 0; g < MON_N; g++) begin : g_mon
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          mon_s1[g] <= '0;
          mon_s2[g] <= '0;
          mon_s3[g] <= '0;
          mon_q[g]  <= '0;
        end else begin
          mon_s1[g] <= line_monitor_inputs[g];
          mon_s2[g] <= mon_s1[g];
          mon_s3[g] <= mon_s2[g];
          if (mon_s2[g] == mon_s3[g]) mon_q[g] <= mon_s3[g];
        end
      end
    end
  endgenerate

  // software registers
  logic [31:0] ctrl;
  logic [31:0] spread;
  logic [31:0] mon_cfg;
  fault_t      fault_sticky;
  logic [31:0] lock_time;
  logic [7:0]  aeq_count;
  link_state_t state;
  link_state_t next_state;

  logic link_reset;
  assign link_reset = ctrl[CTRL_LINK_RESET_BIT];

  // lock sequencing: pixel clock is not an input at all, reference clock only [RULE_12]
  // single link, no second link state exists [RULE_18]
  always_comb begin
    next_state = state;
    case (state)
      ST_DOWN:    if (pd_n && !link_reset) next_state = ST_ACQUIRE;   // [RULE_13] [RULE_10]
      ST_ACQUIRE: if (rx_ok) next_state = ST_LOCKED;                  // [RULE_08]
      ST_LOCKED:  if (!rx_ok) next_state = ST_ACQUIRE;                // retry alone [RULE_21]
      default:    next_state = ST_DOWN;
    endcase
    if (!pd_n || link_reset) next_state = ST_DOWN;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) state <= ST_DOWN;
    else          state <= next_state;
  end

  // lock indicator: open-drain pulls low while unlocked, released when locked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_od_oe      <= 1'b1;
      lock_out        <= 1'b0;
      channels_enable <= 1'b0;
    end else begin
      lock_od_oe      <= (next_state != ST_LOCKED);   // [RULE_11] [RULE_21]
      lock_out        <= 1'b0;
      channels_enable <= (next_state == ST_LOCKED);   // usable at once [RULE_09]
    end
  end

  // lock time counter from the later release; host overlap is assumed [RULE_16] [RULE_14]
  always_ff @(posedge aclk) begin
    if (!aresetn) lock_time <= 32'h0;
    else if (state == ST_DOWN) lock_time <= 32'h0;
    else if (state == ST_ACQUIRE && lock_time != 32'hFFFF_FFFF)
      lock_time <= lock_time + 32'h1;  // [RULE_16]
  end

  // equalizer scheduler: once on entering acquire from down, then every period while locked
  logic [AEQ_CNT_W-1:0] aeq_timer;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aeq_timer <= '0;
      aeq_start <= 1'b0;
      aeq_count <= 8'h0;
    end else begin
      aeq_start <= 1'b0;
      if (state == ST_DOWN && next_state == ST_ACQUIRE) begin
        aeq_start <= 1'b1;                       // initial adaptation [RULE_01]
        aeq_timer <= '0;
      end else if (state == ST_LOCKED) begin
        if (aeq_timer == AEQ_CNT_W'(AEQ_CYCLES - 1)) begin
          aeq_timer <= '0;
          aeq_start <= 1'b1;                     // periodic re-trigger [RULE_01]
        end else begin
          aeq_timer <= aeq_timer + 1'b1;
        end
      end
      if (aeq_done) aeq_count <= aeq_count + 8'h1;
    end
  end

  // rate, error correction and spread clocking outputs
  logic [7:0] sp_freq;
  logic [7:0] sp_dev;
  assign sp_freq = spread[SPREAD_FREQ_LSB +: 8];
  assign sp_dev  = spread[SPREAD_DEV_LSB +: 8];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fwd_rate        <= RATE_3G;
      fec_enable      <= 1'b0;
      spread_clocking <= 1'b0;
      spread_freq_khz <= SPREAD_FREQ_MIN;
      spread_dev      <= 8'h0;
      rx_tolerance    <= RX_TOL_NO_SPREAD;
    end else begin
      // code 3 names no rate, so the last legal rate stays in force
      if (ctrl[CTRL_RATE_LSB +: 2] != 2'h3) fwd_rate <= ctrl[CTRL_RATE_LSB +: 2]; // [RULE_19]
      fec_enable <= ctrl[CTRL_FEC_BIT] ||
                    (ctrl[CTRL_RATE_LSB +: 2] == RATE_12G);       // [RULE_20]
      spread_clocking <= spread[SPREAD_EN_BIT];
      // clamp to the legal window [RULE_02]
      spread_freq_khz <= (sp_freq < SPREAD_FREQ_MIN) ? SPREAD_FREQ_MIN :
                         (sp_freq > SPREAD_FREQ_MAX) ? SPREAD_FREQ_MAX : sp_freq;
      spread_dev <= (sp_dev > SPREAD_DEV_MAX) ? SPREAD_DEV_MAX : sp_dev;
      // receive tolerance widened only while spread clocking is off [RULE_03]
      rx_tolerance <= spread[SPREAD_EN_BIT] ? 8'h0 : RX_TOL_NO_SPREAD;
    end
  end

  // fault classification across monitors
  logic   mon_en;
  logic   mon_stp;
  fault_t fault_now;
  fault_t fault_mask;
  assign mon_en     = mon_cfg[MON_EN_BIT];
  assign mon_stp    = mon_cfg[MON_STP_BIT];
  assign fault_mask = fault_t'(mon_cfg[MON_MASK_LSB +: 4]);
  always_comb begin
    fault_now = '0;
    for (int i = 0; i < MON_N; i++) begin
      fault_now.open      |= mon_q[i].open;          // [RULE_04]
      fault_now.short_bat |= mon_q[i].high;
      fault_now.short_gnd |= mon_q[i].low;
    end
    // both lines of pair zero/one pulled together means line-to-line [RULE_07]
    fault_now.line_short = mon_stp && (MON_N > 1) &&
                           (mon_q[0].high ^ mon_q[0].low) &&
                           (mon_q[1 % MON_N] == mon_q[0]) && !mon_q[0].open;
    if (fault_now.line_short) begin
      fault_now.short_bat = 1'b0;
      fault_now.short_gnd = 1'b0;
    end
    if (!mon_en) fault_now = '0;                     // off from reset [RULE_05]
  end

  // AXI4-Lite write path: address and data taken in either order
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic       wr_go;
  logic       stat_clr;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) if (strb[b]) r[8*b +: 8] = new_v[8*b +: 8];
    return r;
  endfunction

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h0;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      s_axi_wready  <= !w_held && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr <= LOCK_TIME_OFS && aw_addr[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; status writes clear fault bits by writing one
  assign stat_clr = wr_go && aw_addr == MON_STAT_OFS;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl    <= CTRL_RESET;
      spread  <= SPREAD_RESET;
      mon_cfg <= MON_CFG_RESET;                     // monitor disabled [RULE_05]
    end else if (wr_go) begin
      case (aw_addr)
        CTRL_OFS:    ctrl    <= merge(ctrl, w_data, w_strb);
        SPREAD_OFS:  spread  <= merge(spread, w_data, w_strb);
        MON_CFG_OFS: mon_cfg <= merge(mon_cfg, w_data, w_strb);
        default:     ;
      endcase
    end
  end

  // sticky fault status: a new fault wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) fault_sticky <= '0;
    else if (stat_clr && w_strb[0])
      fault_sticky <= (fault_sticky & ~fault_t'(w_data[3:0])) | fault_now;
    else
      fault_sticky <= fault_sticky | fault_now;
  end

  // error output: low only for unmasked faults [RULE_06]
  always_ff @(posedge aclk) begin
    if (!aresetn) error_out_n <= 1'b1;
    else          error_out_n <= ~|(fault_sticky & ~fault_mask);
  end

  // AXI4-Lite read path, one read at a time
  logic [31:0] status_word;
  always_comb begin
    status_word = 32'h0;
    status_word[STAT_LOCK_BIT]             = (state == ST_LOCKED);  // [RULE_11]
    status_word[STAT_STATE_LSB +: 2]       = state;
    status_word[STAT_FEC_BIT]              = fec_enable;
    status_word[STAT_RX_OK_BIT]            = rx_ok;
    status_word[STAT_AEQ_CNT_LSB +: 8]     = aeq_count;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        case (s_axi_araddr)
          CTRL_OFS:      s_axi_rdata <= ctrl;
          STATUS_OFS:    s_axi_rdata <= status_word;
          SPREAD_OFS:    s_axi_rdata <= spread;
          MON_CFG_OFS:   s_axi_rdata <= mon_cfg;
          MON_STAT_OFS:  s_axi_rdata <= {28'h0, fault_sticky};    // [RULE_05]
          LOCK_TIME_OFS: s_axi_rdata <= lock_time;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;                                   // unmapped: SLVERR
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// ### bench/link_ctrl_monitor.sv
// assertion checker for the link control block, bound to its top module
`timescale 1ns/1ps
module link_ctrl_monitor
  import link_ctrl_pkg::*;
#(
  parameter longint AEQ_CYCLES = AEQ_PERIOD_CYC
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       power_down_n_pin,
  input wire logic       rx_path_locked,
  input wire logic       aeq_start,
  input wire logic       lock_od_oe,
  input wire logic       lock_out,
  input wire logic       channels_enable,
  input wire logic [1:0] fwd_rate,
  input wire logic       fec_enable,
  input wire logic       spread_clocking,
  input wire logic [7:0] spread_freq_khz,
  input wire logic [7:0] spread_dev,
  input wire logic       error_out_n
);
  // slack covers the request register and the lock handover
  localparam int AEQ_HI = int'(AEQ_CYCLES) + 4;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_lock_needs_rx: assert property (!rx_path_locked [*8] |=> lock_od_oe)
    else $error("lock shown without receive lock");
  a_chan_follow_lock: assert property (channels_enable == !lock_od_oe)
    else $error("channels enable differs from lock");
  a_lock_pin_od: assert property (!lock_out)
    else $error("lock pin driven high");
  a_fec_at_top: assert property (fwd_rate == RATE_12G |-> fec_enable)
    else $error("top rate without error correction");
  a_freq_in_range: assert property (
    spread_freq_khz inside {[SPREAD_FREQ_MIN:SPREAD_FREQ_MAX]})
    else $error("modulation frequency out of range");
  a_dev_limit: assert property (spread_dev <= SPREAD_DEV_MAX)
    else $error("deviation above limit");
  a_rate_fixed: assert property (fwd_rate != 2'h3)
    else $error("undefined forward rate");
  a_aeq_pulse: assert property (aeq_start |=> !aeq_start)
    else $error("equalizer request longer than a cycle");
  a_aeq_period: assert property (
    aeq_start && channels_enable |-> ##[1:AEQ_HI] (aeq_start || !channels_enable))
    else $error("equalizer not retriggered in time");
  a_pd_drops_lock: assert property (
    !power_down_n_pin [*8] |=> lock_od_oe && !channels_enable)
    else $error("lock held during power down");

  // main scenarios reached
  cover property (!lock_od_oe);
  cover property ($fell(error_out_n));
  cover property (spread_clocking);
  cover property (aeq_start && channels_enable);
endmodule

bind link_lock_and_line_fault_ctrl link_ctrl_monitor #(.AEQ_CYCLES(AEQ_CYCLES)) i_mon (
  .aclk, .aresetn, .power_down_n_pin, .rx_path_locked, .aeq_start, .lock_od_oe,
  .lock_out, .channels_enable, .fwd_rate, .fec_enable, .spread_clocking,
  .spread_freq_khz, .spread_dev, .error_out_n);

// ### bench/far_end_model.sv
// far-end receiver model: reports receive lock and answers equalizer requests
`timescale 1ns/1ps
module far_end_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       far_up,
  input  wire logic [7:0] lock_dly,
  input  wire logic       aeq_start,
  output logic            rx_path_locked,
  output logic            aeq_done
);
  logic [7:0] cnt;
  logic [1:0] done_sr;

  // lock follows lock_dly cycles of a live link; a large delay models a slow far end
  always_ff @(posedge aclk) begin
    if (!aresetn || !far_up) begin
      cnt <= 8'h00;
    end else if (cnt != lock_dly) begin
      cnt <= cnt + 8'h01;
    end
  end
  assign rx_path_locked = far_up && (cnt == lock_dly);

  // adaptation finishes two cycles after each request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_sr <= 2'h0;
    end else begin
      done_sr <= {done_sr[0], aeq_start};
    end
  end
  assign aeq_done = done_sr[1];
endmodule

// ### bench/link_lock_and_line_fault_ctrl_tb_top.sv
// self-checking bench for the link lock and line-fault control block
`timescale 1ns/1ps
module link_lock_and_line_fault_ctrl_tb_top;
  import link_ctrl_pkg::*;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [19:0] q;} row_t;
  // register writes beside the settings they should produce
  localparam row_t ROWS [8] = '{
    '{CTRL_OFS, 32'h0000_0004, 20'h40A00}, '{CTRL_OFS, 32'h0000_0006, 20'h60A00},
    '{CTRL_OFS, 32'h0000_0008, 20'hA0A00}, '{CTRL_OFS, 32'h0000_0000, 20'h00A00},
    '{SPREAD_OFS, 32'h0014_0641, 20'h11464}, '{SPREAD_OFS, 32'h0032_0FF1, 20'h1287D},
    '{SPREAD_OFS, 32'h0005_0001, 20'h10A00}, '{SPREAD_OFS, 32'h0000_0000, 20'h00A00}};
  logic        aclk = 1'b0, aresetn = 1'b0, far_up = 1'b1, power_down_n_pin = 1'b1;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lock_dly = 8'h14;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, fwd_rate;
  logic        rx_path_locked, aeq_done, aeq_start, lock_od_oe, lock_out, error_out_n;
  logic        channels_enable, fec_enable, spread_clocking;
  logic [7:0]  spread_freq_khz, spread_dev, rx_tolerance;
  mon_raw_t [3:0] line_monitor_inputs = '0;
  int          n_errors = 0, n_compared = 0;

  always #50 aclk = ~aclk;

  link_lock_and_line_fault_ctrl #(.MON_N(4), .AEQ_CYCLES(50)) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .power_down_n_pin, .rx_path_locked,
    .line_monitor_inputs, .aeq_done, .aeq_start, .lock_od_oe, .lock_out, .error_out_n,
    .channels_enable, .fwd_rate, .fec_enable, .spread_clocking, .spread_freq_khz,
    .spread_dev, .rx_tolerance);

  far_end_model i_far (.aclk, .aresetn, .far_up, .lock_dly, .aeq_start, .rx_path_locked,
    .aeq_done);

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // each channel is released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    // bready stays high: a back-to-back call would otherwise drive it twice in one step
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(d, e);
  endtask

  // bounded wait: a lock that never comes is reported, not hung on
  task automatic wait_lock(input logic want);
    int n;
    n = 0;
    while (lock_od_oe !== !want && n < 300) begin
      @(posedge aclk);
      n++;
    end
    check(32'(lock_od_oe), 32'(!want));
  endtask

  task automatic summarize;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // the whole sequence needs about 700 cycles
  initial begin
    repeat (8000) @(posedge aclk);
    n_errors++;
    summarize;
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    check(32'({lock_od_oe, error_out_n, channels_enable}), 32'h6);
    // no bus traffic and no pixel clock: the link must lock on its own
    wait_lock(1'b1);
    check(32'(channels_enable), 32'h1);
    rd(STATUS_OFS, d, r);
    check(32'(d[STAT_LOCK_BIT]), 32'h1);
    $display("test auto lock done");
    // monitor still off, so a faulted line must stay silent
    line_monitor_inputs[2] <= 3'h1;
    rchk(CTRL_OFS, CTRL_RESET);
    rchk(SPREAD_OFS, SPREAD_RESET);
    rchk(MON_CFG_OFS, MON_CFG_RESET);
    rchk(MON_STAT_OFS, 32'h0);
    check(32'(error_out_n), 32'h1);
    rd(8'h40, d, r);
    check({d[29:0], r}, 32'h2);
    wr(8'h42, 32'hFFFF_FFFF, r);
    check(32'(r), 32'h2);
    $display("test reset and unmapped done");
    n = 0;
    repeat (160) begin
      @(posedge aclk);
      n += int'(aeq_start);
    end
    check(32'(n >= 3 && n <= 4), 32'h1);
    rd(STATUS_OFS, d, r);
    check(32'(d[STAT_AEQ_CNT_LSB +: 8] >= 8'h3), 32'h1);
    $display("test equalizer period done");
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d, r);
      @(posedge aclk);
      d = 32'({r, fwd_rate, fec_enable, spread_clocking, spread_freq_khz, spread_dev});
      check(d, 32'(ROWS[i].q));
      check(32'(rx_tolerance), ROWS[i].q[16] ? 32'h0 : 32'(RX_TOL_NO_SPREAD));
    end
    // rate code 3 names no rate and must never reach the link
    wr(CTRL_OFS, 32'h0000_000C, r);
    @(posedge aclk);
    check(32'(fwd_rate), 32'(RATE_3G));
    $display("test settings table done");
    line_monitor_inputs <= '0;
    wr(MON_CFG_OFS, 32'h1, r);
    wr(MON_STAT_OFS, 32'hF, r);
    // open, low and high conditions map to open, short to ground, short to battery
    for (int k = 0; k < 3; k++) begin
      line_monitor_inputs[2] <= mon_raw_t'(3'h1 << k);
      repeat (8) @(posedge aclk);
      check(32'(error_out_n), 32'h0);
      rchk(MON_STAT_OFS, 32'h1 << (k == 0 ? 0 : 3 - k));
      line_monitor_inputs[2] <= 3'h0;
      repeat (8) @(posedge aclk);
      wr(MON_STAT_OFS, 32'hF, r);
      @(posedge aclk);
      check(32'(error_out_n), 32'h1);
    end
    wr(MON_CFG_OFS, 32'h11, r);
    line_monitor_inputs[1] <= 3'h1;
    repeat (8) @(posedge aclk);
    check(32'(error_out_n), 32'h1);
    line_monitor_inputs <= '0;
    wr(MON_CFG_OFS, 32'h3, r);
    wr(MON_STAT_OFS, 32'hF, r);
    line_monitor_inputs[3:2] <= {3'h2, 3'h2};
    repeat (8) @(posedge aclk);
    rchk(MON_STAT_OFS, 32'h4);
    line_monitor_inputs <= {3'h0, 3'h0, 3'h2, 3'h2};
    repeat (8) @(posedge aclk);
    wr(MON_STAT_OFS, 32'hF, r);
    rd(MON_STAT_OFS, d, r);
    check(32'(d[3]), 32'h1);
    line_monitor_inputs <= '0;
    $display("test line faults done");
    // both ends held in reset together, then released within a cycle of each other
    wr(CTRL_OFS, 32'h1, r);
    far_up <= 1'b0;
    repeat (10) @(posedge aclk);
    check(32'(lock_od_oe), 32'h1);
    rchk(LOCK_TIME_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0, r);
    far_up <= 1'b1;
    wait_lock(1'b1);
    rd(LOCK_TIME_OFS, d, r);
    check(32'(d >= 32'd20 && d <= 32'd32), 32'h1);
    $display("test link reset done");
    power_down_n_pin <= 1'b0;
    far_up <= 1'b0;
    repeat (10) @(posedge aclk);
    check(32'({lock_od_oe, channels_enable}), 32'h2);
    lock_dly <= 8'h5A;
    power_down_n_pin <= 1'b1;
    far_up <= 1'b1;
    wait_lock(1'b1);
    $display("test power down done");
    // brief line upset: no host reset is issued while the link recovers
    far_up <= 1'b0;
    wait_lock(1'b0);
    far_up <= 1'b1;
    wait_lock(1'b1);
    $display("test lock loss done");
    summarize;
  end
endmodule
